// ### src/uefp_pkg.sv
// Package for the endpoint FIFO partition block: register map, field layout and types.
package uefp_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [11:0] UEFP_TX_SIZE_OFF = 12'h000;
    localparam logic [11:0] UEFP_RX_SIZE_OFF = 12'h004;
    localparam logic [11:0] UEFP_TX_START_OFF = 12'h008;
    localparam logic [11:0] UEFP_RX_START_OFF = 12'h00C;
    localparam logic [11:0] UEFP_TX_GEOM_OFF = 12'h010;
    localparam logic [11:0] UEFP_RX_GEOM_OFF = 12'h014;

    // ----------------------------------------------------------------
    // Field layout
    // ----------------------------------------------------------------
    localparam int UEFP_DBL_BIT = 4;
    localparam int UEFP_CODE_W = 4;
    localparam int UEFP_START_W = 13;
    localparam int UEFP_UNIT_SHIFT = 3;
    localparam int UEFP_SINGLE_EXP = 3;
    localparam int UEFP_DOUBLE_EXP = 4;
    localparam int UEFP_BYTE_ADDR_W = 16;
    localparam int UEFP_EXTENT_W = 20;
    localparam logic [31:0] UEFP_ZERO_WORD = 32'h0000_0000;
    localparam logic [3:0] UEFP_CODE_RST = 4'h0;
    localparam logic [12:0] UEFP_START_RST = 13'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic double_buffer_select;
        logic [UEFP_CODE_W-1:0] fifo_size_code;
    } uefp_size_t;

    typedef struct packed {
        logic [UEFP_BYTE_ADDR_W-1:0] base;
        logic [UEFP_EXTENT_W-1:0] extent;
    } uefp_region_t;

    typedef enum logic [1:0] {
        UEFP_IDLE = 2'b00,
        UEFP_ACCESS = 2'b01
    } uefp_state_t;

endpackage

// ### src/uefp_partition.sv
// APB register block that partitions the shared packet RAM among endpoint FIFOs.
module uefp_partition #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output uefp_pkg::uefp_region_t tx_region,
    output uefp_pkg::uefp_region_t rx_region,
    output logic [uefp_pkg::UEFP_EXTENT_W-1:0] tx_max_packet,
    output logic [uefp_pkg::UEFP_EXTENT_W-1:0] rx_max_packet
);
    import uefp_pkg::*;

    // Offsets are decoded from the low twelve address bits; wider buses would alias.
    if (ADDR_W < 5 || ADDR_W > 12) begin : g_addr_check
        $error("ADDR_W outside the range the register map decodes");
    end

    // ----------------------------------------------------------------
    // Configuration state
    // ----------------------------------------------------------------
    uefp_size_t tx_endpoint_fifo_size;
    uefp_size_t rx_endpoint_fifo_size;
    logic [UEFP_START_W-1:0] tx_endpoint_fifo_start;
    logic [UEFP_START_W-1:0] rx_endpoint_fifo_start;
    uefp_state_t state;

    // ----------------------------------------------------------------
    // Geometry arithmetic
    // ----------------------------------------------------------------
    // One packet of the given code; also the largest accepted packet.
    function automatic logic [UEFP_EXTENT_W-1:0] packet_bytes(input logic [UEFP_CODE_W-1:0] code);
        packet_bytes = UEFP_EXTENT_W'(1) << (UEFP_EXTENT_W'(code) + UEFP_EXTENT_W'(UEFP_SINGLE_EXP));
    endfunction

    function automatic logic [UEFP_EXTENT_W-1:0] footprint(input uefp_size_t cfg);
        if (cfg.double_buffer_select) begin
            footprint = UEFP_EXTENT_W'(1) << (UEFP_EXTENT_W'(cfg.fifo_size_code)
                + UEFP_EXTENT_W'(UEFP_DOUBLE_EXP));
        end else begin
            footprint = packet_bytes(cfg.fifo_size_code);
        end
    endfunction

    function automatic logic [UEFP_BYTE_ADDR_W-1:0] start_bytes(input logic [UEFP_START_W-1:0] units);
        start_bytes = UEFP_BYTE_ADDR_W'(units) << UEFP_UNIT_SHIFT;
    endfunction

    function automatic logic [31:0] size_word(input uefp_size_t cfg);
        size_word = {27'h0000000, cfg};
    endfunction

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire logic [11:0] offset = 12'(paddr);
    wire logic setup = psel && !penable;
    wire logic hit_tx_size = offset == UEFP_TX_SIZE_OFF;
    wire logic hit_rx_size = offset == UEFP_RX_SIZE_OFF;
    wire logic hit_tx_start = offset == UEFP_TX_START_OFF;
    wire logic hit_rx_start = offset == UEFP_RX_START_OFF;
    wire logic hit_tx_geom = offset == UEFP_TX_GEOM_OFF;
    wire logic hit_rx_geom = offset == UEFP_RX_GEOM_OFF;
    wire logic mapped = hit_tx_size || hit_rx_size || hit_tx_start || hit_rx_start || hit_tx_geom || hit_rx_geom;
    // Geometry words are read-only; writing them is refused.
    wire logic bad = !mapped || (pwrite && (hit_tx_geom || hit_rx_geom));
    wire logic wr_ok = psel && penable && pwrite && !bad;
    wire uefp_size_t wr_size = uefp_size_t'(pwdata[UEFP_DBL_BIT:0]);
    wire logic [UEFP_START_W-1:0] wr_start = pwdata[UEFP_START_W-1:0];

    wire uefp_region_t next_tx_region = '{start_bytes(tx_endpoint_fifo_start),
        footprint(tx_endpoint_fifo_size)};
    wire uefp_region_t next_rx_region = '{start_bytes(rx_endpoint_fifo_start),
        footprint(rx_endpoint_fifo_size)};

    wire logic [31:0] geom_tx = {12'h000, next_tx_region.extent};
    wire logic [31:0] geom_rx = {12'h000, next_rx_region.extent};
    wire logic [31:0] next_prdata =
        (pwrite || bad) ? UEFP_ZERO_WORD :
        hit_tx_size ? size_word(tx_endpoint_fifo_size) :
        hit_rx_size ? size_word(rx_endpoint_fifo_size) :
        hit_tx_start ? {19'h00000, tx_endpoint_fifo_start} :
        hit_rx_start ? {19'h00000, rx_endpoint_fifo_start} :
        hit_tx_geom ? geom_tx : geom_rx;

    // ----------------------------------------------------------------
    // Bus state: setup is taken, the answer stands during the access.
    // ----------------------------------------------------------------
    // The answer is launched at the setup edge; the write waits for the access edge where pready is seen.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state <= UEFP_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= UEFP_ZERO_WORD;
        end else begin
            case (state)
                UEFP_IDLE: begin
                    if (setup) begin
                        state <= UEFP_ACCESS;
                        pready <= 1'b1;
                        pslverr <= bad;
                        prdata <= next_prdata;
                    end
                end
                UEFP_ACCESS: begin
                    state <= UEFP_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    prdata <= UEFP_ZERO_WORD;
                end
                default: begin
                    state <= UEFP_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_endpoint_fifo_size <= '{1'b0, UEFP_CODE_RST};
            rx_endpoint_fifo_size <= '{1'b0, UEFP_CODE_RST};
            tx_endpoint_fifo_start <= UEFP_START_RST;
            rx_endpoint_fifo_start <= UEFP_START_RST;
        end else if (wr_ok && state == UEFP_ACCESS) begin
            if (hit_tx_size) tx_endpoint_fifo_size <= wr_size;
            if (hit_rx_size) rx_endpoint_fifo_size <= wr_size;
            if (hit_tx_start) tx_endpoint_fifo_start <= wr_start;
            if (hit_rx_start) rx_endpoint_fifo_start <= wr_start;
        end
    end

    // ----------------------------------------------------------------
    // Region outputs, registered one cycle behind the fields.
    // ----------------------------------------------------------------
    // Overlap between regions is software's to prevent; nothing here checks it.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            tx_region <= '0;
            rx_region <= '0;
            tx_max_packet <= '0;
            rx_max_packet <= '0;
        end else begin
            tx_region <= next_tx_region;
            rx_region <= next_rx_region;
            tx_max_packet <= packet_bytes(tx_endpoint_fifo_size.fifo_size_code);
            rx_max_packet <= packet_bytes(rx_endpoint_fifo_size.fifo_size_code);
        end
    end

endmodule

// ### tb/uefp_partition_assertions.sv
// Checker for the endpoint FIFO partition block, bound to every instance of it.
module uefp_partition_assertions
    import uefp_pkg::*;
#(parameter int ADDR_W = 12) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire uefp_pkg::uefp_region_t tx_region,
    input wire uefp_pkg::uefp_region_t rx_region,
    input wire logic [uefp_pkg::UEFP_EXTENT_W-1:0] tx_max_packet,
    input wire logic [uefp_pkg::UEFP_EXTENT_W-1:0] rx_max_packet
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [19:0] ext(logic [4:0] s);
        return 20'h1 << (s[3:0] + 3 + s[4]);
    endfunction
    sequence setup(logic w, logic [11:0] a);
        psel && !penable && pwrite == w && paddr == a;
    endsequence
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    tx_size_a: assert property (setup(1'h1, UEFP_TX_SIZE_OFF) |-> ##3
        tx_region.extent == ext($past(pwdata[4:0], 3)) && tx_max_packet == ext({1'h0, $past(pwdata[3:0], 3)}))
        else $error("tx extent wrong");
    rx_size_a: assert property (setup(1'h1, UEFP_RX_SIZE_OFF) |-> ##3
        rx_region.extent == ext($past(pwdata[4:0], 3)) && rx_max_packet == ext({1'h0, $past(pwdata[3:0], 3)}))
        else $error("rx extent wrong");
    tx_base_a: assert property (setup(1'h1, UEFP_TX_START_OFF) |-> ##3
        tx_region.base == {$past(pwdata[12:0], 3), 3'h0}) else $error("tx base wrong");
    rx_base_a: assert property (setup(1'h1, UEFP_RX_START_OFF) |-> ##3
        rx_region.base == {$past(pwdata[12:0], 3), 3'h0}) else $error("rx base wrong");
    size_reserved_a: assert property (setup(1'h0, UEFP_TX_SIZE_OFF) or setup(1'h0, UEFP_RX_SIZE_OFF)
        |=> pready && prdata[31:5] == 27'h0) else $error("size reserved bits set");
    start_reserved_a: assert property (setup(1'h0, UEFP_TX_START_OFF) or setup(1'h0, UEFP_RX_START_OFF)
        |=> pready && prdata[31:13] == 19'h0) else $error("start reserved bits set");
    answer_pulse_a: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("answer not a single pulse");
    reset_clear_a: assert property ($rose(nrst) |-> tx_region.base == 16'h0 && rx_region.base == 16'h0)
        else $error("base not cleared");
endmodule

bind uefp_partition uefp_partition_assertions #(.ADDR_W(ADDR_W)) chk (.mclk, .nrst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_region, .rx_region, .tx_max_packet, .rx_max_packet);

// ### tb/uefp_partition_tb.sv
// Self-checking bench for the endpoint FIFO partition block.
module uefp_partition_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import uefp_pkg::*;
    logic mclk = 1'h0, nrst = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err, pready, pslverr;
    logic [11:0] paddr = 12'h0, a;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic [19:0] tx_max_packet, rx_max_packet, mp;
    uefp_region_t tx_region, rx_region, rg;
    int error_cnt = 0, total_checks = 0, cycles = 0, seed = 53567;
    logic [11:0] offs[4] = '{UEFP_TX_SIZE_OFF, UEFP_RX_SIZE_OFF, UEFP_TX_START_OFF, UEFP_RX_START_OFF};
    always #2.5 mclk = ~mclk;
    uefp_partition uut (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .tx_region, .rx_region, .tx_max_packet, .rx_max_packet);
    function automatic logic [19:0] ext(logic [4:0] s);
        return 20'h1 << (s[3:0] + 3 + s[4]);
    endfunction
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(logic wr, logic [11:0] ad, logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // The ceiling sits far above the fewer than nine hundred cycles the sequence needs.
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge mclk);
        nrst <= 1'h1;
        for (int r = 0; r < 2; r++) begin
            foreach (offs[j]) begin
                apb(1'h0, offs[j], 32'h0);
                chk("reset value", rd, 32'h0);
            end
            if (r == 0) begin
                for (int i = 0; i < 64; i++) begin
                    v = $random(seed);
                    v[4:0] = i[4:0];
                    a = i[5] ? UEFP_RX_SIZE_OFF : UEFP_TX_SIZE_OFF;
                    apb(1'h1, a, v);
                    apb(1'h0, a, 32'h0);
                    chk("size readback", rd, {27'h0, v[4:0]});
                    chk("size error", {31'h0, err}, 32'h0);
                    apb(1'h0, i[5] ? UEFP_RX_GEOM_OFF : UEFP_TX_GEOM_OFF, 32'h0);
                    rg = i[5] ? rx_region : tx_region;
                    mp = i[5] ? rx_max_packet : tx_max_packet;
                    chk("extent readback", rd, {12'h0, ext(v[4:0])});
                    chk("extent", {12'h0, rg.extent}, {12'h0, ext(v[4:0])});
                    chk("max packet", {12'h0, mp}, {12'h0, ext({1'h0, v[3:0]})});
                end
                for (int i = 0; i < 40; i++) begin
                    v = (i < 2) ? 32'hFFFF_FFFF : $random(seed);
                    a = i[0] ? UEFP_RX_START_OFF : UEFP_TX_START_OFF;
                    apb(1'h1, a, v);
                    apb(1'h0, a, 32'h0);
                    rg = i[0] ? rx_region : tx_region;
                    chk("start readback", rd, {19'h0, v[12:0]});
                    chk("base", {16'h0, rg.base}, {16'h0, v[12:0], 3'h0});
                end
                // Software places a doubled transmit FIFO and the receive FIFO end to end.
                apb(1'h1, UEFP_TX_SIZE_OFF, 32'h13);
                apb(1'h1, UEFP_TX_START_OFF, 32'h0);
                apb(1'h1, UEFP_RX_SIZE_OFF, 32'h3);
                apb(1'h1, UEFP_RX_START_OFF, 32'h10);
                repeat (2) @(posedge mclk);
                chk("tx end", {16'h0, tx_region.base} + {12'h0, tx_region.extent}, 32'h80);
                chk("rx start", {16'h0, rx_region.base}, 32'h80);
                apb(1'h1, UEFP_TX_GEOM_OFF, 32'hFFFF_FFFF);
                chk("geometry write refused", {31'h0, err}, 32'h1);
                apb(1'h0, 12'h018, 32'h0);
                chk("unmapped refused", {31'h0, err}, 32'h1);
                chk("unmapped data", rd, 32'h0);
                @(posedge mclk);
                nrst <= 1'h0;
                repeat (2) @(posedge mclk);
                nrst <= 1'h1;
            end
        end
        end_of_test();
    end
endmodule
